// ==== shared/vic_pkg.sv ====
// Purpose: constants and types of the vectored interrupt controller
// Assumes: single clk domain, byte-addressed register port
// Notes:   16 maskable sources plus a trap request and a non-maskable request
// Summary of operation
// R1: Eighteen sources, each with own vector entry
// R2: One trap, one non-maskable, rest maskable
// R3: Trap and non-maskable ignore global disable
// R4: Trap and non-maskable outrank every maskable
// R5: Each maskable source gated by own mask
// R6: Fixed default order plus two programmable levels
// R7: Vectored request branches CPU to entry address
// R8: Macroservice request starts transfer, no program
// R9: Trap instruction raises trap, vector 003EH
// R10: Non-maskable pin edge, vector 0002H, no macroservice
// R11: Pin zero edge is source 0, 0006H
// R12: Request flags read/write by bit, byte, word
// R13: Mask flags reset FFFFH, bit/byte/word access
// R14: Level flags reset FFFFH, bit/byte/word access
// R15: Service method flags reset 0000H, any width
// R16: Two pin edge mode registers, reset 00H
// R17: State register bit/byte access, reset 00H
// R18: Global enable and level flag gate acceptance
// R19: Only six sources may use macroservice
// R20: Set mask bit blocks; all blocked after reset
// R21: Higher level first, then lowest default number
// R22: Flag set by event, cleared on acknowledge
package vic_pkg;
  localparam int          NUM_MASK   = 16;
  localparam logic [15:0] ADR_IF_L   = 16'hFFE0;
  localparam logic [15:0] ADR_IF_H   = 16'hFFE1;
  localparam logic [15:0] ADR_MK_L   = 16'hFFE4;
  localparam logic [15:0] ADR_MK_H   = 16'hFFE5;
  localparam logic [15:0] ADR_PR_L   = 16'hFFE8;
  localparam logic [15:0] ADR_PR_H   = 16'hFFE9;
  localparam logic [15:0] ADR_ISM_L  = 16'hFFEC;
  localparam logic [15:0] ADR_ISM_H  = 16'hFFED;
  localparam logic [15:0] ADR_MODE_A = 16'hFFF4;
  localparam logic [15:0] ADR_MODE_B = 16'hFFF5;
  localparam logic [15:0] ADR_IST    = 16'hFFF8;
  localparam logic [15:0] RST_IF     = 16'h0000;
  localparam logic [15:0] RST_MK     = 16'hFFFF;
  localparam logic [15:0] RST_PR     = 16'hFFFF;
  localparam logic [15:0] RST_ISM    = 16'h0000;
  localparam logic [7:0]  RST_MODE   = 8'h00;
  localparam logic [7:0]  RST_IST    = 8'h00;
  // Sources 6,7,9,13,14,15 may be serviced by transfer
  localparam logic [15:0] MS_CAPABLE = 16'hE2C0;
  // Sources fed by on-chip peripherals rather than pins
  localparam logic [15:0] PERIPH_SRC = 16'hF1F0;
  // External pins 6..0 map to these source numbers
  localparam logic [6:0][3:0] PIN_SRC = {4'hB, 4'hA, 4'h9, 4'h3, 4'h2, 4'h1, 4'h0};
  localparam int          IST_NMI_BIT = 0;
  localparam int          NMI_PIN_BIT = 7;
  localparam logic [4:0]  SRC_NMI    = 5'h10;
  localparam logic [4:0]  SRC_TRAP   = 5'h11;
  localparam logic [1:0]  SZ_BIT     = 2'h0;
  localparam logic [1:0]  SZ_BYTE    = 2'h1;
  localparam logic [1:0]  SZ_WORD    = 2'h2;
  localparam logic [15:0] VEC_NMI    = 16'h0002;
  localparam logic [15:0] VEC_TRAP   = 16'h003E;
  localparam logic [15:0][15:0] VEC_MASK = {
    16'h0026, 16'h0024, 16'h0022, 16'h0020, 16'h0012, 16'h0010, 16'h000E, 16'h001C,
    16'h001A, 16'h0018, 16'h0016, 16'h0014, 16'h000C, 16'h000A, 16'h0008, 16'h0006};
  typedef enum logic [1:0] {ST_IDLE, ST_LOOK, ST_VEC, ST_MS} vic_state_t;
endpackage

// ==== hdl/vic_vec_rom.sv ====
// Purpose: vector table, one entry per source, registered read
// Assumes: index 0..15 maskable, 16 non-maskable, 17 trap
// Notes:   one cycle from index to data
`timescale 1ns/10ps
module vic_vec_rom
  import vic_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Lookup
  input  wire logic [4:0]  idx,
  output logic      [15:0] vec_ff
);
  logic [15:0] nxt_vec;

  always_comb begin
    if (idx == SRC_TRAP) begin
      nxt_vec = VEC_TRAP;
    end else if (idx == SRC_NMI) begin
      nxt_vec = VEC_NMI;
    end else if (idx < SRC_NMI) begin
      nxt_vec = VEC_MASK[idx[3:0]]; // see R1
    end else begin
      nxt_vec = 16'h0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vec_ff <= 16'h0000;
    end else begin
      vec_ff <= nxt_vec;
    end
  end
endmodule

// ==== hdl/vic_core.sv ====
// Purpose: request collection, masking, priority and dispatch
// Assumes: CPU holds global enable and level flag, answers with one-cycle acks
// Notes:   register port is the CPU's own special-register access
`timescale 1ns/10ps
module vic_core
  import vic_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register access
  input  wire logic [15:0] sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [1:0]  sfr_size,
  input  wire logic [2:0]  sfr_bit,
  input  wire logic [15:0] sfr_wdata,
  output logic      [15:0] sfr_rdata,
  // Request sources
  input  wire logic        nmi_pin,
  input  wire logic [6:0]  ext_pin,
  input  wire logic [15:0] periph_evt,
  input  wire logic        trap_instruction,
  // CPU state
  input  wire logic        global_request_enable_flag,
  input  wire logic        current_level_flag,
  // Vectored dispatch
  output logic             vec_req,
  output logic      [15:0] vec_addr,
  output logic             vec_high,
  input  wire logic        vec_ack,
  // Macroservice dispatch
  output logic             ms_req,
  output logic      [3:0]  ms_src,
  input  wire logic        ms_ack
);
  typedef struct packed {
    logic [7:0]  sync1;
    logic [7:0]  sync2;
    logic [7:0]  prev;
    logic [15:0] pend;
    logic [15:0] mask;
    logic [15:0] level;
    logic [15:0] method;
    logic [7:0]  mode_a;
    logic [7:0]  mode_b;
    logic [7:0]  state;
    logic        nmi_pend;
    logic        trap_pend;
    vic_state_t  st;
    logic [4:0]  cur;
    logic        cur_ms;
    logic        vec_req;
    logic        vec_high;
    logic        ms_req;
    logic [15:0] rdata;
  } vic_regs_t;

  vic_regs_t   s_ff;
  vic_regs_t   nxt_s;
  logic [15:0] vec_rom;
  logic [7:0]  edge_sel;
  logic [7:0]  edges;
  logic [15:0] evt;
  logic [15:0] elig;
  logic [15:0] elig_hi;
  logic [4:0]  pick_hi;
  logic [4:0]  pick_lo;
  logic [4:0]  pick;

  function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [15:0] t);
    logic       hit;
    logic [7:0] d;
    logic [7:0] m;
    hit = sfr_wr && ((sfr_addr == t) ||
          (sfr_size == SZ_WORD && !sfr_addr[0] && {sfr_addr[15:1], 1'b1} == t));
    d = (sfr_size == SZ_WORD && t[0]) ? sfr_wdata[15:8] : sfr_wdata[7:0];
    m = (sfr_size == SZ_BIT) ? (8'h01 << sfr_bit) : 8'hFF;
    return hit ? ((old & ~m) | (d & m)) : old;
  endfunction

  function automatic logic [7:0] rd_byte(input vic_regs_t r, input logic [15:0] a);
    unique case (a)
      ADR_IF_L:   return r.pend[7:0];
      ADR_IF_H:   return r.pend[15:8];
      ADR_MK_L:   return r.mask[7:0];
      ADR_MK_H:   return r.mask[15:8];
      ADR_PR_L:   return r.level[7:0];
      ADR_PR_H:   return r.level[15:8];
      ADR_ISM_L:  return r.method[7:0];
      ADR_ISM_H:  return r.method[15:8];
      ADR_MODE_A: return r.mode_a;
      ADR_MODE_B: return r.mode_b;
      ADR_IST:    return r.state;
      default:    return 8'h00;
    endcase
  endfunction

  // Lowest numbered set bit wins; bit 4 flags a hit
  function automatic logic [4:0] first_set(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = NUM_MASK - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  vic_vec_rom u_rom (
    .clk    (clk),
    .rst_n  (rst_n),
    .idx    (s_ff.cur),
    .vec_ff (vec_rom)
  );

  always_comb begin
    nxt_s       = s_ff;
    // Pins are asynchronous; only the second stage feeds the edge logic
    nxt_s.sync1 = {nmi_pin, ext_pin};
    nxt_s.sync2 = s_ff.sync1;
    nxt_s.prev  = s_ff.sync2;
    // Mode bit 1 selects rising edge, 0 falling
    edge_sel = {s_ff.mode_a[7], s_ff.mode_b[2:0], s_ff.mode_a[3:0]};
    edges    = (s_ff.sync2 & ~s_ff.prev & edge_sel) | (~s_ff.sync2 & s_ff.prev & ~edge_sel);
    evt      = periph_evt & PERIPH_SRC;
    for (int i = 0; i < 7; i++) begin
      evt[PIN_SRC[i]] = evt[PIN_SRC[i]] | edges[i]; // see R11
    end

    // Register writes
    nxt_s.pend   = {wr_byte(s_ff.pend[15:8], ADR_IF_H), wr_byte(s_ff.pend[7:0], ADR_IF_L)}; // see R12
    nxt_s.mask   = {wr_byte(s_ff.mask[15:8], ADR_MK_H), wr_byte(s_ff.mask[7:0], ADR_MK_L)}; // see R13
    nxt_s.level  = {wr_byte(s_ff.level[15:8], ADR_PR_H), wr_byte(s_ff.level[7:0], ADR_PR_L)}; // see R14
    nxt_s.method = {wr_byte(s_ff.method[15:8], ADR_ISM_H),
                    wr_byte(s_ff.method[7:0], ADR_ISM_L)} & MS_CAPABLE; // see R15 see R19
    nxt_s.mode_a = wr_byte(s_ff.mode_a, ADR_MODE_A); // see R16
    nxt_s.mode_b = wr_byte(s_ff.mode_b, ADR_MODE_B);
    nxt_s.state  = wr_byte(s_ff.state, ADR_IST); // see R17

    // Read data, registered; unmapped bytes read zero
    nxt_s.rdata = s_ff.rdata;
    if (sfr_rd) begin
      nxt_s.rdata[7:0]  = rd_byte(s_ff, sfr_addr);
      nxt_s.rdata[15:8] = (sfr_size == SZ_WORD) ? rd_byte(s_ff, sfr_addr | 16'h0001) : 8'h00;
    end

    // Eligible: unmasked, enabled, and level allowed by CPU status
    elig    = s_ff.pend & ~s_ff.mask & {NUM_MASK{global_request_enable_flag}}; // see R5 R20 R18
    elig    = elig & (current_level_flag ? 16'hFFFF : ~s_ff.level); // see R18
    elig_hi = elig & ~s_ff.level; // see R6
    pick_hi = first_set(elig_hi);
    pick_lo = first_set(elig);
    pick    = pick_hi[4] ? pick_hi : pick_lo; // see R21

    unique case (s_ff.st)
      ST_IDLE: begin
        // Trap and non-maskable bypass the enable and outrank all others
        if (s_ff.trap_pend) begin
          nxt_s.cur    = SRC_TRAP; // see R3 R4 R9
          nxt_s.cur_ms = 1'b0;
          nxt_s.st     = ST_LOOK;
        end else if (s_ff.nmi_pend && !s_ff.state[IST_NMI_BIT]) begin
          nxt_s.cur    = SRC_NMI; // see R3 R4 R10
          nxt_s.cur_ms = 1'b0;
          nxt_s.st     = ST_LOOK;
        end else if (pick[4]) begin // see R2
          nxt_s.cur      = {1'b0, pick[3:0]};
          nxt_s.cur_ms   = s_ff.method[pick[3:0]]; // see R19
          nxt_s.vec_high = !s_ff.level[pick[3:0]];
          nxt_s.st       = ST_LOOK;
        end
      end
      ST_LOOK: begin
        if (s_ff.cur_ms) begin
          nxt_s.ms_req = 1'b1; // see R8
          nxt_s.st     = ST_MS;
        end else begin
          nxt_s.vec_req = 1'b1; // see R7
          nxt_s.st      = ST_VEC;
        end
      end
      ST_VEC: begin
        if (vec_ack) begin
          nxt_s.vec_req  = 1'b0;
          nxt_s.vec_high = 1'b0;
          nxt_s.st       = ST_IDLE;
          if (s_ff.cur == SRC_TRAP) begin
            nxt_s.trap_pend = 1'b0;
          end else if (s_ff.cur == SRC_NMI) begin
            nxt_s.nmi_pend = 1'b0;
            // Blocks a nested non-maskable until software clears it
            nxt_s.state[IST_NMI_BIT] = 1'b1;
          end else begin
            nxt_s.pend[s_ff.cur[3:0]] = 1'b0; // see R22
          end
        end
      end
      ST_MS: begin
        if (ms_ack) begin
          nxt_s.ms_req              = 1'b0;
          nxt_s.vec_high            = 1'b0;
          nxt_s.pend[s_ff.cur[3:0]] = 1'b0; // see R22
          nxt_s.st                  = ST_IDLE;
        end
      end
    endcase

    // Events last so that a set wins over any clear in the same cycle
    nxt_s.pend      = nxt_s.pend | evt; // see R22
    nxt_s.nmi_pend  = nxt_s.nmi_pend | edges[NMI_PIN_BIT]; // see R10
    nxt_s.trap_pend = nxt_s.trap_pend | trap_instruction; // see R9
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff        <= '0;
      s_ff.pend   <= RST_IF;
      s_ff.mask   <= RST_MK;
      s_ff.level  <= RST_PR;
      s_ff.method <= RST_ISM;
      s_ff.mode_a <= RST_MODE;
      s_ff.mode_b <= RST_MODE;
      s_ff.state  <= RST_IST;
      s_ff.st     <= ST_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign sfr_rdata = s_ff.rdata;
  assign vec_req   = s_ff.vec_req;
  assign vec_addr  = vec_rom;
  assign vec_high  = s_ff.vec_high;
  assign ms_req    = s_ff.ms_req;
  assign ms_src    = s_ff.cur[3:0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_take_mask;
    (s_ff.st == ST_IDLE) ##1 (s_ff.st == ST_LOOK && s_ff.cur < SRC_NMI);
  endsequence

  property p_trap_addr;
    $rose(vec_req) && s_ff.cur == SRC_TRAP |-> vec_addr == VEC_TRAP;
  endproperty
  a_trap_addr: assert property (p_trap_addr) else $error("trap vector wrong"); // see R9

  property p_nmi_addr;
    vec_req && s_ff.cur == SRC_NMI |-> vec_addr == VEC_NMI;
  endproperty
  a_nmi_addr: assert property (p_nmi_addr) else $error("nmi vector wrong"); // see R10

  property p_pin0_addr;
    vec_req && s_ff.cur == 5'h00 |-> vec_addr == VEC_MASK[0];
  endproperty
  a_pin0_addr: assert property (p_pin0_addr) else $error("pin zero vector wrong"); // see R11

  property p_ms_capable;
    ms_req |-> MS_CAPABLE[ms_src] && s_ff.cur < SRC_NMI;
  endproperty
  a_ms_capable: assert property (p_ms_capable) else $error("transfer on bad source"); // see R19

  property p_method_bits;
    (s_ff.method & ~MS_CAPABLE) == 16'h0000;
  endproperty
  a_method_bits: assert property (p_method_bits) else $error("method bit on bad source"); // see R19

  property p_enable_gate;
    s_take_mask |-> $past(global_request_enable_flag, 1);
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("taken while disabled"); // see R18

  property p_mask_gate;
    // Shift rather than select: a sampled value cannot be indexed directly
    s_take_mask |-> (($past(s_ff.mask, 1) >> s_ff.cur[3:0]) & 16'h0001) == 16'h0000;
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("masked source taken"); // see R5

  property p_trap_first;
    s_ff.st == ST_IDLE && s_ff.trap_pend |=> s_ff.st == ST_LOOK && s_ff.cur == SRC_TRAP ##1 vec_req;
  endproperty
  a_trap_first: assert property (p_trap_first) else $error("trap not first"); // see R3

  property p_vec_hold;
    vec_req && !vec_ack |=> vec_req && $stable(vec_addr);
  endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("vector request dropped"); // see R7

  property p_ms_hold;
    ms_req && !ms_ack |=> ms_req && $stable(ms_src);
  endproperty
  a_ms_hold: assert property (p_ms_hold) else $error("transfer request dropped"); // see R8

  property p_nmi_block;
    s_ff.st == ST_IDLE && s_ff.state[IST_NMI_BIT]
      |=> !(s_ff.st == ST_LOOK && s_ff.cur == SRC_NMI);
  endproperty
  a_nmi_block: assert property (p_nmi_block) else $error("nested non-maskable taken"); // see R10

  property p_ack_clear;
    s_ff.st == ST_VEC && vec_ack && s_ff.cur < SRC_NMI && !evt[s_ff.cur[3:0]]
      |=> !s_ff.pend[$past(s_ff.cur[3:0])];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("flag not cleared on ack"); // see R22
endmodule

// ==== tb/vic_cpu_model.sv ====
// Purpose: CPU side of dispatch, acknowledges vector and transfer requests
// Assumes: each request is held until its acknowledge
// Notes:   slow inserts wait states so held requests are exercised
`timescale 1ns/10ps
module vic_cpu_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Requests and pacing
  input  wire logic vec_req,
  input  wire logic ms_req,
  input  wire logic slow,
  // Acknowledges
  output logic      vec_ack,
  output logic      ms_ack
);
  logic [1:0] wait_ff;
  logic       done_ff;

  // One ack per request; done blocks a second ack while req falls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_ff <= 2'h0;
      done_ff <= 1'b0;
      vec_ack <= 1'b0;
      ms_ack  <= 1'b0;
    end else begin
      vec_ack <= 1'b0;
      ms_ack  <= 1'b0;
      if (!(vec_req || ms_req)) begin
        done_ff <= 1'b0;
        wait_ff <= 2'h0;
      end else if (!done_ff) begin
        if (wait_ff == (slow ? 2'h3 : 2'h0)) begin
          vec_ack <= vec_req;
          ms_ack  <= ms_req;
          done_ff <= 1'b1;
        end else begin
          wait_ff <= wait_ff + 2'h1;
        end
      end
    end
  end
endmodule

// ==== tb/vic_core_tb_top.sv ====
// Purpose: self-checking bench for the interrupt controller
// Assumes: driver queues expectations, monitor compares results
// Notes:   unexpected requests are compared against an impossible value
`timescale 1ns/10ps
module vic_core_tb_top
  import vic_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [1:0]  size = 2'h0;
  logic [2:0]  bitn = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic        nmi = 1'b1;
  logic [6:0]  pin = 7'h7F;
  logic [15:0] evt = 16'h0000;
  logic        trap = 1'b0;
  logic        en = 1'b0;
  logic        lvl = 1'b1;
  logic        slow = 1'b0;
  logic [15:0] rdata, vaddr, r, m;
  logic        vreq, vhigh, vack, mreq, mack;
  logic [3:0]  msrc;
  logic [19:0] expq[$];
  logic        rd_q = 1'b0;
  logic        rd_q2 = 1'b0;
  logic        vreq_d = 1'b0;
  logic        mreq_d = 1'b0;
  int          fail_count = 0;
  int          n_checks = 0;
  int          k;

  always #5 clk = ~clk;

  vic_core vic_core_inst (
    .clk(clk), .rst_n(rst_n), .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd),
    .sfr_size(size), .sfr_bit(bitn), .sfr_wdata(wdata), .sfr_rdata(rdata),
    .nmi_pin(nmi), .ext_pin(pin), .periph_evt(evt), .trap_instruction(trap),
    .global_request_enable_flag(en), .current_level_flag(lvl),
    .vec_req(vreq), .vec_addr(vaddr), .vec_high(vhigh), .vec_ack(vack),
    .ms_req(mreq), .ms_src(msrc), .ms_ack(mack));

  vic_cpu_model vic_cpu_model_inst (
    .clk(clk), .rst_n(rst_n), .vec_req(vreq), .ms_req(mreq), .slow(slow),
    .vec_ack(vack), .ms_ack(mack));

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (fail_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic note(input logic [19:0] seen);
    if (expq.size() == 0) begin
      check(seen, 20'hFFFFF);
    end else begin
      check(seen, expq.pop_front());
    end
  endtask

  // Kind in the top nibble: 1 read, 2 vector, 3 high-level vector, 4 transfer
  always @(posedge clk) begin
    rd_q <= rd;
    rd_q2 <= rd_q;
  end
  always @(negedge clk) begin
    vreq_d <= vreq;
    mreq_d <= mreq;
    if (rd_q2) note({4'h1, rdata});
    if (vreq && !vreq_d) note({vhigh ? 4'h3 : 4'h2, vaddr});
    if (mreq && !mreq_d) note({4'h4, 12'h000, msrc});
  end

  task automatic wr_reg(input logic [15:0] a, input logic [1:0] s, input logic [2:0] b,
                        input logic [15:0] d);
    @(negedge clk);
    addr = a;
    size = s;
    bitn = b;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [15:0] a, input logic [1:0] s, input logic [15:0] e);
    expq.push_back({4'h1, e});
    @(negedge clk);
    addr = a;
    size = s;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
  endtask

  task automatic pulse(input logic [15:0] e, input logic t);
    @(negedge clk);
    evt = e;
    trap = t;
    @(negedge clk);
    evt = 16'h0000;
    trap = 1'b0;
  endtask

  // Settle first so a spurious request still shows, then bounded wait
  task automatic drain();
    int i;
    repeat (8) @(negedge clk);
    for (i = 0; i < 60; i++) begin
      if (expq.size() == 0 && !vreq && !mreq) break;
      @(negedge clk);
    end
    if (i == 60) begin
      fail_count++;
      results();
    end
  endtask

  initial begin
    r = 16'($urandom(32'hd2cb));
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    rd_reg(ADR_IF_L, SZ_WORD, RST_IF);
    rd_reg(ADR_MK_L, SZ_WORD, RST_MK);
    rd_reg(ADR_PR_L, SZ_WORD, RST_PR);
    rd_reg(ADR_ISM_L, SZ_WORD, RST_ISM);
    rd_reg(ADR_MODE_A, SZ_BYTE, {8'h00, RST_MODE});
    rd_reg(ADR_MODE_B, SZ_BYTE, {8'h00, RST_MODE});
    rd_reg(ADR_IST, SZ_BYTE, {8'h00, RST_IST});
    rd_reg(16'hFFF0, SZ_BYTE, 16'h0000);
    for (k = 0; k < 4; k++) begin
      r = 16'($urandom());
      wr_reg(ADR_PR_L, SZ_WORD, 3'h0, r);
      rd_reg(ADR_PR_L, SZ_WORD, r);
      wr_reg(ADR_MK_H, SZ_BYTE, 3'h0, r);
      wr_reg(ADR_MK_H, SZ_BIT, k[2:0], 16'h00FF);
      m = {r[7:0] | (8'h01 << k), 8'hFF};
      rd_reg(ADR_MK_L, SZ_WORD, m);
      wr_reg(ADR_ISM_L, SZ_WORD, 3'h0, r);
      rd_reg(ADR_ISM_L, SZ_WORD, r & MS_CAPABLE);
    end
    wr_reg(ADR_PR_L, SZ_WORD, 3'h0, 16'hFFFF);
    wr_reg(ADR_MK_L, SZ_WORD, 3'h0, 16'hFFFF);
    wr_reg(ADR_ISM_L, SZ_WORD, 3'h0, 16'h0000);
    // Masked event stays pending until its mask bit clears
    en = 1'b1;
    pulse(16'h0010, 1'b0);
    drain();
    rd_reg(ADR_IF_L, SZ_WORD, 16'h0010);
    expq.push_back({4'h2, VEC_MASK[4]});
    wr_reg(ADR_MK_L, SZ_BIT, 3'h4, 16'h0000);
    drain();
    rd_reg(ADR_IF_L, SZ_WORD, 16'h0000);
    // Every maskable source on its own, pins on falling edges
    wr_reg(ADR_MK_L, SZ_WORD, 3'h0, 16'h0000);
    for (k = 0; k < NUM_MASK; k++) begin
      slow = k[0];
      expq.push_back({4'h2, VEC_MASK[k]});
      if (PERIPH_SRC[k]) pulse(16'h0001 << k, 1'b0);
      else pin[k < 4 ? k : k - 5] = 1'b0;
      drain();
      pin = 7'h7F;
    end
    // Rising-edge selection on pins 0 and 4
    wr_reg(ADR_MODE_A, SZ_BYTE, 3'h0, 16'h0001);
    wr_reg(ADR_MODE_B, SZ_BIT, 3'h0, 16'h00FF);
    pin = 7'h6E;
    drain();
    expq.push_back({4'h2, VEC_MASK[0]});
    expq.push_back({4'h2, VEC_MASK[9]});
    pin = 7'h7F;
    drain();
    // Trap outranks a high-level maskable request
    wr_reg(ADR_PR_L, SZ_WORD, 3'h0, 16'hEFFF);
    expq.push_back({4'h2, VEC_TRAP});
    expq.push_back({4'h3, VEC_MASK[12]});
    pulse(16'h1000, 1'b1);
    drain();
    // Non-maskable while disabled, then held off while in service
    en = 1'b0;
    expq.push_back({4'h2, VEC_NMI});
    nmi = 1'b0;
    drain();
    rd_reg(ADR_IST, SZ_BYTE, 16'h0001);
    nmi = 1'b1;
    drain();
    nmi = 1'b0;
    drain();
    expq.push_back({4'h2, VEC_NMI});
    wr_reg(ADR_IST, SZ_BYTE, 3'h0, 16'h0000);
    drain();
    // Level flag admits only high level, then default order
    pulse(16'h1120, 1'b0);
    drain();
    expq.push_back({4'h3, VEC_MASK[12]});
    lvl = 1'b0;
    en = 1'b1;
    drain();
    rd_reg(ADR_IF_L, SZ_WORD, 16'h0120);
    expq.push_back({4'h2, VEC_MASK[5]});
    expq.push_back({4'h2, VEC_MASK[8]});
    lvl = 1'b1;
    drain();
    // Transfer for a capable source, vector for an incapable one
    wr_reg(ADR_ISM_L, SZ_WORD, 3'h0, 16'h0050);
    expq.push_back({4'h2, VEC_MASK[4]});
    expq.push_back({4'h4, 16'h0006});
    pulse(16'h0050, 1'b0);
    drain();
    // Trap and rising non-maskable edge while disabled
    en = 1'b0;
    wr_reg(ADR_IST, SZ_BYTE, 3'h0, 16'h0000);
    wr_reg(ADR_MODE_A, SZ_BIT, 3'h7, 16'h00FF);
    expq.push_back({4'h2, VEC_TRAP});
    expq.push_back({4'h2, VEC_NMI});
    pulse(16'h0000, 1'b1);
    nmi = 1'b1;
    drain();
    rd_reg(ADR_MODE_A, SZ_BIT, 16'h0081);
    drain();
    results();
  end
endmodule
